// >>> rtl/dct_ctl.sv
// dct_ctl: memory controller end, makes the link clock and spaces commands
`timescale 1ns/10ps
module dct_ctl (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // requests
  input wire logic req_valid_in,
  input wire dct_pkg::dct_cmd_t req_cmd_in,
  input wire logic bc4_fixed_in,
  input wire logic hot_in,
  // answers
  output logic ack_out,
  output logic busy_out,
  output logic pd_out,
  output logic wl_fb_out,
  // link
  dct_if.ctl link
);
  import dct_pkg::*;

  typedef enum logic [1:0] {ST_RUN, ST_PD, ST_WL} dct_state_t;

  dct_state_t state;
  logic ck;
  logic tick;
  logic [CNT_W-1:0] rfc_cnt;
  logic [CNT_W-1:0] refi_cnt;
  logic [CNT_W-1:0] xpdll_cnt;
  logic [CNT_W-1:0] pden_cnt;
  logic [CNT_W-1:0] wl_en_cnt;
  logic [CNT_W-1:0] wl_first_cnt;
  logic fb_meta;
  logic fb_sync;
  logic refresh_due;
  logic grant;
  logic do_ref;

  // commands change at ck's falling edge, so the device sees them settled at its rising edge
  assign tick = ce_in && ck;
  assign refresh_due = refi_cnt == '0;

  // link clock divider
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ck <= 1'b0;
    end else if (ce_in) begin
      ck <= !ck;
    end
  end

  assign link.ck = ck;

  // gate each request on its spacing
  always_comb begin
    grant = 1'b0;
    // a due refresh must not lock out the only exits from power-down and leveling
    if (CK_PERIOD_OK && req_valid_in && (!refresh_due || state != ST_RUN)) begin
      case (req_cmd_in)
        CMD_ACT: grant = state == ST_RUN && rfc_cnt == '0;
        CMD_REF: grant = state == ST_RUN && rfc_cnt == '0;
        CMD_RD, CMD_RDA, CMD_ODT: grant = state == ST_RUN && xpdll_cnt == '0;
        CMD_PRE, CMD_WR, CMD_SHORT_IMPEDANCE_CALIBRATION: grant = state == ST_RUN;
        CMD_WL_ON: grant = state == ST_RUN;
        CMD_WL_OFF: grant = state == ST_WL;
        CMD_PD_ENTER: grant = state == ST_RUN && pden_cnt == '0;
        CMD_PD_EXIT: grant = state == ST_PD;
        default: grant = 1'b0;
      endcase
    end
  end

  // refresh is forced ahead of user traffic, outside power-down and leveling
  assign do_ref = refresh_due && state == ST_RUN && rfc_cnt == '0;

  // command issue and state
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_RUN;
      link.cmd <= CMD_NOP;
      link.cke <= 1'b1;
      ack_out <= 1'b0;
    end else if (ce_in) begin
      ack_out <= 1'b0;
      if (tick) begin
        link.cmd <= CMD_NOP;
        if (do_ref) begin
          link.cmd <= CMD_REF;
        end else if (grant) begin
          ack_out <= 1'b1;
          case (req_cmd_in)
            CMD_PD_ENTER: begin
              link.cke <= 1'b0;
              state <= ST_PD;
            end
            CMD_PD_EXIT: begin
              link.cke <= 1'b1;
              state <= ST_RUN;
            end
            CMD_WL_ON: begin
              link.cmd <= CMD_WL_ON;
              state <= ST_WL;
            end
            CMD_WL_OFF: begin
              link.cmd <= CMD_WL_OFF;
              state <= ST_RUN;
            end
            default: link.cmd <= req_cmd_in;
          endcase
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rfc_cnt <= '0;
    end else if (tick) begin
      if (do_ref || (grant && req_cmd_in == CMD_REF)) begin
        rfc_cnt <= CNT_W'(REFRESH_CYCLE_NCK);
      end else if (rfc_cnt != '0) begin
        rfc_cnt <= rfc_cnt - CNT_W'(1);
      end
    end
  end

  // slow clocks still refresh on time
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      refi_cnt <= CNT_W'(REFI_HOT_NCK);
    end else if (tick) begin
      if (do_ref || (grant && req_cmd_in == CMD_REF)) begin
        refi_cnt <= hot_in ? CNT_W'(REFI_HOT_NCK) : CNT_W'(REFI_COOL_NCK);
      end else if (hot_in && refi_cnt > CNT_W'(REFI_HOT_NCK)) begin
        // turning hot shortens the pending wait at once
        refi_cnt <= CNT_W'(REFI_HOT_NCK);
      end else if (refi_cnt != '0 && state != ST_PD) begin
        refi_cnt <= refi_cnt - CNT_W'(1);
      end else if (refi_cnt != '0 && state == ST_PD) begin
        refi_cnt <= refi_cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xpdll_cnt <= '0;
    end else if (tick) begin
      if (grant && req_cmd_in == CMD_PD_EXIT) begin
        xpdll_cnt <= CNT_W'(FROZEN_EXIT_NCK);
      end else if (xpdll_cnt != '0) begin
        xpdll_cnt <= xpdll_cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pden_cnt <= '0;
    end else if (tick) begin
      if (grant && req_cmd_in == CMD_WR) begin
        pden_cnt <= bc4_fixed_in ? CNT_W'(WRITE_LATENCY_CYCLES + WR_START_CHOP4 + WRITE_RECOVERY_NCK)
                                 : CNT_W'(WRITE_LATENCY_CYCLES + WR_START_BURST8 + WRITE_RECOVERY_NCK);
      end else if (pden_cnt != '0) begin
        pden_cnt <= pden_cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wl_en_cnt <= '0;
      wl_first_cnt <= '0;
      link.dqs_oe <= 1'b0;
      link.dqs_o <= 1'b0;
    end else if (tick) begin
      if (grant && req_cmd_in == CMD_WL_ON) begin
        wl_en_cnt <= CNT_W'(WL_STROBE_EN_NCK);
        wl_first_cnt <= CNT_W'(WL_FIRST_STROBE_NCK);
      end else begin
        if (wl_en_cnt != '0) begin
          wl_en_cnt <= wl_en_cnt - CNT_W'(1);
        end
        if (wl_first_cnt != '0) begin
          wl_first_cnt <= wl_first_cnt - CNT_W'(1);
        end
      end
      link.dqs_oe <= state == ST_WL && wl_en_cnt == '0 && !(grant && req_cmd_in == CMD_WL_OFF);
      // one strobe pulse per two link cycles keeps edges well apart
      link.dqs_o <= state == ST_WL && wl_first_cnt == '0 && !link.dqs_o;
    end
  end

  // bus chop flag, busy and power-down status
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link.bc4_fixed <= 1'b0;
      busy_out <= 1'b0;
      pd_out <= 1'b0;
    end else if (ce_in) begin
      link.bc4_fixed <= bc4_fixed_in;
      busy_out <= req_valid_in && !grant;
      pd_out <= state == ST_PD;
    end
  end

  // feedback crosses from the link clock
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fb_meta <= 1'b0;
      fb_sync <= 1'b0;
      wl_fb_out <= 1'b0;
    end else if (ce_in) begin
      fb_meta <= link.wl_fb;
      fb_sync <= fb_meta;
      wl_fb_out <= fb_sync;
    end
  end
endmodule : dct_ctl

// >>> rtl/dct_pkg.sv
// dct_pkg: shared constants, command codes and timing counts for both dram ends
// Contract
// - refresh cycle time before activate or refresh
// - average refresh spacing 7.8 or 3.9 us
// - first strobe edge 40 cycles after leveling
// - strobe drive enabled 25 cycles after leveling
// - only reads and sync termination need lock
// - write recovery over clock period, round up
// - internal write starts latency plus 4 or 2
// - device finishes row operations before power-down
// - refresh then power-down may need relock delay
// - short calibration completes within 64 clock cycles
// - any long clock period if refresh met
// - clock period meets read and write latency
// - frozen exit waits max of 10 cycles, 24 ns
package dct_pkg;
  typedef enum logic [3:0] {
    CMD_NOP, CMD_ACT, CMD_PRE, CMD_REF, CMD_WR, CMD_RD, CMD_RDA, CMD_ODT,
    CMD_SHORT_IMPEDANCE_CALIBRATION, CMD_WL_ON, CMD_WL_OFF, CMD_PD_ENTER, CMD_PD_EXIT
  } dct_cmd_t;

  localparam int CNT_W = 8;
  localparam int SYS_PERIOD_NS = 40;
  // link clock toggles every system cycle
  localparam int CK_PERIOD_NS = 2 * SYS_PERIOD_NS;

  localparam int CK_MIN_READ_LAT_NS = 1;
  localparam int CK_MIN_WRITE_LAT_NS = 1;
  localparam bit CK_PERIOD_OK = (CK_PERIOD_NS >= CK_MIN_READ_LAT_NS) && (CK_PERIOD_NS >= CK_MIN_WRITE_LAT_NS);

  localparam int REFRESH_CYCLE_NS = 90;
  localparam int REFRESH_CYCLE_NCK = (REFRESH_CYCLE_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
  localparam int REFI_COOL_NS = 7800;
  localparam int REFI_HOT_NS = 3900;
  // longest times round down
  localparam int REFI_COOL_NCK = REFI_COOL_NS / CK_PERIOD_NS;
  localparam int REFI_HOT_NCK = REFI_HOT_NS / CK_PERIOD_NS;

  localparam int WL_FIRST_STROBE_NCK = 40;
  localparam int WL_STROBE_EN_NCK = 25;

  localparam int FROZEN_EXIT_MIN_NCK = 10;
  localparam int FROZEN_EXIT_NS = 24;
  localparam int FROZEN_EXIT_NS_NCK = (FROZEN_EXIT_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
  localparam int FROZEN_EXIT_NCK = (FROZEN_EXIT_MIN_NCK > FROZEN_EXIT_NS_NCK) ? FROZEN_EXIT_MIN_NCK
                                                                              : FROZEN_EXIT_NS_NCK;

  localparam int WRITE_RECOVERY_NS = 15;
  localparam int WRITE_RECOVERY_NCK = (WRITE_RECOVERY_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
  localparam int WRITE_LATENCY_CYCLES = 5;
  localparam int WR_START_BURST8 = 4;
  localparam int WR_START_CHOP4 = 2;

  localparam int SHORT_IMPEDANCE_CALIBRATION_NCK = 64;
  localparam int ROW_OP_NCK = 4;
endpackage : dct_pkg

// >>> rtl/dct_if.sv
// dct_if: link between memory controller end and dram device end
`timescale 1ns/10ps
interface dct_if;
  import dct_pkg::*;
  logic ck;
  logic cke;
  dct_cmd_t cmd;
  logic bc4_fixed;
  logic dqs_o;
  logic dqs_oe;
  logic dqs;
  logic wl_fb;

  // undriven strobe reads low
  assign dqs = dqs_oe ? dqs_o : 1'b0;

  modport ctl (output ck, output cke, output cmd, output bc4_fixed, output dqs_o, output dqs_oe,
               input wl_fb);
  modport dev (input ck, input cke, input cmd, input bc4_fixed, input dqs, output wl_fb);
endinterface : dct_if

// >>> rtl/dct_dev.sv
// dct_dev: dram device end, clocked by the link clock
`timescale 1ns/10ps
module dct_dev (
  // control
  input wire logic rst_n_in,
  input wire logic ce_in,
  // link
  dct_if.dev link,
  // status
  output logic wr_start_out,
  output logic pd_active_out,
  output logic zq_busy_out,
  output logic viol_out
);
  import dct_pkg::*;

  logic [CNT_W-1:0] wr_cnt;
  logic [CNT_W-1:0] op_cnt;
  logic [CNT_W-1:0] ref_cnt;
  logic [CNT_W-1:0] zq_cnt;
  logic [CNT_W-1:0] lock_cnt;
  logic cke_q;
  logic wl_mode;
  logic next_viol;

  always_ff @(posedge link.ck or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_cnt <= '0;
      wr_start_out <= 1'b0;
    end else if (ce_in) begin
      wr_start_out <= (wr_cnt == CNT_W'(1));
      if (link.cke && link.cmd == CMD_WR) begin
        wr_cnt <= link.bc4_fixed ? CNT_W'(WRITE_LATENCY_CYCLES + WR_START_CHOP4)
                                 : CNT_W'(WRITE_LATENCY_CYCLES + WR_START_BURST8);
      end else if (wr_cnt != '0) begin
        wr_cnt <= wr_cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge link.ck or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op_cnt <= '0;
      ref_cnt <= '0;
      pd_active_out <= 1'b0;
    end else if (ce_in) begin
      if (link.cke && (link.cmd == CMD_ACT || link.cmd == CMD_PRE || link.cmd == CMD_RDA)) begin
        op_cnt <= CNT_W'(ROW_OP_NCK);
      end else if (op_cnt != '0) begin
        op_cnt <= op_cnt - CNT_W'(1);
      end
      if (link.cke && link.cmd == CMD_REF) begin
        ref_cnt <= CNT_W'(REFRESH_CYCLE_NCK);
      end else if (ref_cnt != '0) begin
        ref_cnt <= ref_cnt - CNT_W'(1);
      end
      // power-down only once row operations and refresh are done
      pd_active_out <= !link.cke && op_cnt == '0 && ref_cnt == '0;
    end
  end

  always_ff @(posedge link.ck or negedge rst_n_in) begin
    if (!rst_n_in) begin
      zq_cnt <= '0;
      zq_busy_out <= 1'b0;
    end else if (ce_in) begin
      if (link.cke && link.cmd == CMD_SHORT_IMPEDANCE_CALIBRATION) begin
        zq_cnt <= CNT_W'(SHORT_IMPEDANCE_CALIBRATION_NCK - 1);
        zq_busy_out <= 1'b1;
      end else if (zq_cnt != '0) begin
        zq_cnt <= zq_cnt - CNT_W'(1);
      end else begin
        zq_busy_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge link.ck or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cke_q <= 1'b1;
      lock_cnt <= '0;
    end else if (ce_in) begin
      cke_q <= link.cke;
      if (link.cke && !cke_q) begin
        lock_cnt <= CNT_W'(FROZEN_EXIT_NCK - 1);
      end else if (lock_cnt != '0) begin
        lock_cnt <= lock_cnt - CNT_W'(1);
      end
    end
  end

  always_comb begin
    next_viol = 1'b0;
    if (link.cke) begin
      case (link.cmd)
        CMD_RD, CMD_RDA, CMD_ODT: next_viol = lock_cnt != '0 || (link.cke && !cke_q);
        CMD_ACT, CMD_REF: next_viol = ref_cnt != '0;
        default: next_viol = 1'b0;
      endcase
    end
  end

  always_ff @(posedge link.ck or negedge rst_n_in) begin
    if (!rst_n_in) begin
      viol_out <= 1'b0;
    end else if (ce_in) begin
      viol_out <= next_viol;
    end
  end

  // leveling feedback samples the strobe
  always_ff @(posedge link.ck or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wl_mode <= 1'b0;
      link.wl_fb <= 1'b0;
    end else if (ce_in) begin
      if (link.cke && link.cmd == CMD_WL_ON) begin
        wl_mode <= 1'b1;
      end else if (link.cke && link.cmd == CMD_WL_OFF) begin
        wl_mode <= 1'b0;
      end
      link.wl_fb <= wl_mode && link.dqs;
    end
  end
endmodule : dct_dev

// >>> tb/dct_asserts.sv
// dct_asserts: protocol checks on the link between the two dram ends
`timescale 1ns/10ps
module dct_asserts (
  // clocks and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // link
  input wire logic ck,
  input wire logic cke,
  input wire dct_pkg::dct_cmd_t cmd,
  input wire logic bc4_fixed,
  input wire logic dqs_oe,
  input wire logic dqs
);
  import dct_pkg::*;
  // two system cycles of slack for the crossing
  localparam int OE_MIN = 2 * WL_STROBE_EN_NCK - 2;
  localparam int DQS_MIN = 2 * WL_FIRST_STROBE_NCK - 2;
  logic [7:0] wl_cnt;
  logic lvl;
  // system cycles since leveling was commanded
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wl_cnt <= 8'h00;
    end else if (cmd == CMD_WL_ON && $changed(cmd)) begin
      wl_cnt <= 8'h01;
    end else if (wl_cnt != 8'h00 && wl_cnt != 8'hFF) begin
      wl_cnt <= wl_cnt + 8'h01;
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lvl <= 1'b0;
    end else if (cmd == CMD_WL_ON) begin
      lvl <= 1'b1;
    end else if (cmd == CMD_WL_OFF) begin
      lvl <= 1'b0;
    end
  end
  sequence s_no_lock;
    !(cmd inside {CMD_RD, CMD_RDA, CMD_ODT});
  endsequence
  sequence s_wr_quiet;
    cke [*8] ##1 (bc4_fixed or cke [*2]);
  endsequence
  a_ref_spacing: assert property (@(posedge ck) disable iff (!rst_n_in)
    cmd == CMD_REF |=> !(cmd inside {CMD_ACT, CMD_REF}))
    else $error("command inside refresh cycle time");
  a_relock_wait: assert property (@(posedge ck) disable iff (!rst_n_in)
    $rose(cke) |-> s_no_lock [*8] ##1 s_no_lock [*2])
    else $error("locked command too soon after exit");
  a_wr_pd_gap: assert property (@(posedge ck) disable iff (!rst_n_in)
    cmd == CMD_WR |-> s_wr_quiet)
    else $error("power-down too soon after write");
  a_oe_early: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    dqs_oe |-> wl_cnt >= OE_MIN)
    else $error("strobe enabled too early");
  a_oe_bound: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    lvl && wl_cnt == 8'h38 |-> dqs_oe)
    else $error("strobe never enabled");
  a_strobe_early: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    dqs |-> wl_cnt >= DQS_MIN)
    else $error("strobe rose too early");
  a_cmd_one_ck: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    cmd != CMD_NOP && $changed(cmd) |=> $stable(cmd) ##1 $changed(cmd))
    else $error("command not one link cycle");
  a_cmd_at_fall: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $changed(cmd) || $changed(cke) |-> $fell(ck))
    else $error("link changed off the falling edge");
  a_ck_divides: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ck |=> !ck ##1 ck)
    else $error("link clock not half rate");
endmodule : dct_asserts

// >>> tb/testbench.sv
// testbench: both ends on one link, a second device driven by hand
`timescale 1ns/10ps
module testbench;
  import dct_pkg::*;
  typedef struct {dct_cmd_t cmd; logic flag; int cnt; dct_cmd_t out;} dct_row_t;
  localparam int WL8 = WRITE_LATENCY_CYCLES + WR_START_BURST8;
  localparam int WL4 = WRITE_LATENCY_CYCLES + WR_START_CHOP4;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  dct_cmd_t req_cmd = CMD_NOP;
  logic bc4 = 1'b0;
  logic hot = 1'b0;
  logic ack, busy, pd, wr_start, pd_act, zq_busy, viol, viol2, bz, ak, wl_fb;
  logic viol_seen = 1'b0;
  logic fb_seen = 1'b0;
  int failures = 0;
  int check_count = 0;
  int ref_count = 0;
  int n;
  // flag is chop mode, cnt the write start delay, out the link command
  dct_row_t rows [9] = '{'{CMD_ACT, 0, 0, CMD_ACT}, '{CMD_PRE, 0, 0, CMD_PRE}, '{CMD_WR, 0, WL8, CMD_WR},
    '{CMD_RD, 0, 0, CMD_RD}, '{CMD_WR, 1, WL4, CMD_WR}, '{CMD_RDA, 0, 0, CMD_RDA},
    '{CMD_ODT, 0, 0, CMD_ODT}, '{CMD_REF, 0, 0, CMD_REF}, '{CMD_ACT, 0, 0, CMD_ACT}};
  // flag is the expected violation, cnt the cycles after exit
  dct_row_t locks [4] = '{'{CMD_RD, 1, 9, CMD_NOP}, '{CMD_RDA, 0, 10, CMD_NOP},
    '{CMD_ACT, 0, 1, CMD_NOP}, '{CMD_ODT, 1, 1, CMD_NOP}};
  dct_if link ();
  dct_if link2 ();
  dct_ctl dct_ctl_inst (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .ce_in(1'b1), .req_valid_in(req_valid),
    .req_cmd_in(req_cmd), .bc4_fixed_in(bc4), .hot_in(hot), .ack_out(ack), .busy_out(busy), .pd_out(pd),
    .wl_fb_out(wl_fb), .link(link.ctl));
  dct_dev dct_dev_inst (.rst_n_in(rst_n), .ce_in(1'b1), .link(link.dev), .wr_start_out(wr_start),
    .pd_active_out(pd_act), .zq_busy_out(zq_busy), .viol_out(viol));
  dct_dev dct_dev_inst2 (.rst_n_in(rst_n), .ce_in(1'b1), .link(link2.dev), .wr_start_out(),
    .pd_active_out(), .zq_busy_out(), .viol_out(viol2));
  dct_asserts dct_asserts_inst (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .ck(link.ck), .cke(link.cke),
    .cmd(link.cmd), .bc4_fixed(link.bc4_fixed), .dqs_oe(link.dqs_oe), .dqs(link.dqs));
  always #20 sys_clk = ~sys_clk;
  always @(posedge link.ck) begin
    if (link.cmd == CMD_REF) ref_count++;
  end
  // viol is registered at the rising edge, so look half a cycle later
  always @(negedge link.ck) begin
    if (viol === 1'b1) viol_seen = 1'b1;
  end
  always @(negedge sys_clk) begin
    if (wl_fb === 1'b1) fb_seen = 1'b1;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic issue(input dct_cmd_t c, input logic b, input dct_cmd_t e);
    int k;
    @(negedge sys_clk);
    bc4 = b;
    req_cmd = c;
    req_valid = 1'b1;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (ack !== 1'b1 && k < 400);
    req_valid = 1'b0;
    @(posedge link.ck);
    #1;
    check(8'(link.cmd), 8'(e));
  endtask : issue
  initial begin
    #1000000;
    failures++;
    test_done();
  end
  initial begin
    link2.ck = 1'b0;
    forever #62.5 link2.ck = ~link2.ck;
  end
  initial begin
    link2.cke = 1'b1;
    link2.cmd = CMD_NOP;
    link2.bc4_fixed = 1'b0;
    link2.dqs_o = 1'b0;
    link2.dqs_oe = 1'b0;
    repeat (4) @(negedge sys_clk);
    check(8'({link.cke, link.dqs_oe, ack, pd}), 8'h08);
    check(8'(link.cmd), 8'(CMD_NOP));
    rst_n = 1'b1;
    foreach (rows[i]) begin
      issue(rows[i].cmd, rows[i].flag, rows[i].out);
      if (rows[i].cnt != 0) begin
        n = 0;
        do begin
          @(posedge link.ck);
          #1;
          n++;
        end while (wr_start !== 1'b1 && n < 30);
        check(8'(n), 8'(rows[i].cnt));
      end
    end
    issue(CMD_SHORT_IMPEDANCE_CALIBRATION, 1'b0, CMD_SHORT_IMPEDANCE_CALIBRATION);
    n = 0;
    do begin
      @(posedge link.ck);
      #1;
      n++;
    end while (zq_busy === 1'b1 && n < 100);
    check(8'(n > 1 && n <= SHORT_IMPEDANCE_CALIBRATION_NCK), 8'h01);
    // write then power-down at once: entry must wait out recovery
    issue(CMD_WR, 1'b0, CMD_WR);
    issue(CMD_PD_ENTER, 1'b0, CMD_NOP);
    @(negedge sys_clk);
    req_cmd = CMD_RD;
    req_valid = 1'b1;
    bz = 1'b0;
    ak = 1'b0;
    repeat (6) begin
      @(negedge sys_clk);
      bz = bz | busy;
      ak = ak | ack;
    end
    req_valid = 1'b0;
    check(8'({bz, ak, pd, pd_act}), 8'h0B);
    issue(CMD_PD_EXIT, 1'b0, CMD_NOP);
    issue(CMD_RD, 1'b0, CMD_RD);
    check(8'(pd), 8'h00);
    issue(CMD_ACT, 1'b0, CMD_ACT);
    issue(CMD_PD_ENTER, 1'b0, CMD_NOP);
    check(8'(pd_act), 8'h00);
    repeat (20) @(negedge sys_clk);
    check(8'(pd_act), 8'h01);
    issue(CMD_PD_EXIT, 1'b0, CMD_NOP);
    issue(CMD_RD, 1'b0, CMD_RD);
    fb_seen = 1'b0;
    issue(CMD_WL_ON, 1'b0, CMD_WL_ON);
    repeat (100) @(negedge sys_clk);
    check(8'(link.dqs_oe), 8'h01);
    check(8'(fb_seen), 8'h01);
    issue(CMD_WL_OFF, 1'b0, CMD_WL_OFF);
    repeat (10) @(negedge sys_clk);
    check(8'(link.dqs_oe), 8'h00);
    for (int h = 0; h < 2; h++) begin
      hot = h[0];
      repeat (200) @(negedge sys_clk);
      ref_count = 0;
      repeat (2000) @(negedge sys_clk);
      check(8'(ref_count >= 1000 / (h ? REFI_HOT_NCK : REFI_COOL_NCK)), 8'h01);
    end
    check(8'(ref_count > 0), 8'h01);
    // hand driven device: locked commands early after exit are flagged
    foreach (locks[i]) begin
      @(negedge link2.ck);
      link2.cke = 1'b0;
      repeat (4) @(negedge link2.ck);
      link2.cke = 1'b1;
      repeat (locks[i].cnt) @(negedge link2.ck);
      link2.cmd = locks[i].cmd;
      @(posedge link2.ck);
      #1;
      check(8'(viol2), 8'(locks[i].flag));
      @(negedge link2.ck);
      link2.cmd = CMD_NOP;
    end
    check(8'(viol_seen), 8'h00);
    test_done();
  end
endmodule : testbench
